/* File: bpeh_pkg.sv */
// Constants, types and register map of the bridge parity error handler.
// Assumes one clock shared with the primary and secondary bus engines.
// Summary of operation
// - Check address parity on both buses for every address phase and command.
// - Primary address parity error with primary response set: do not claim.
// - Secondary address parity error with secondary response set: do not claim.
// - Any address parity error sets that interface's detected-parity-error bit.
// - Address parity error raises primary system error when enable and response set.
// - Forwarded data parity passes across the bridge unaltered.
// - Own config write with bad parity: ready, write, parity error if enabled.
// - Downstream read error: secondary detected; if enabled, error after two cycles.
// - Upstream read error: primary detected; if enabled, error after two cycles.
// - Bad-parity read data returned intact; unread prefetched data discarded.
// - Initiator parity error on returned read data causes no bridge action.
// - Queued delayed write captures address, command, data, enables, data parity; retry.
// - Bad initial delayed write, response set: ready, not queued, stop if multi-phase, error.
// - Response clear: retry and queue without error; detected bit always set.
// - Target error on delivery sets target-side data-parity bit if that side's response is set, and is captured.
// - Repeat completes only on exact match, parity bit excluded.
// - Bad repeat with status pending: ready, error if enabled, entry stays.
// - Error passed back from target: initiator error if both responses set.

package bpeh_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_P_STAT = 8'h04;
   localparam logic [7:0] REG_S_STAT = 8'h08;
   localparam logic [7:0] REG_DW_STATE = 8'h0c;

   // Control bits.
   localparam int CT_P_RESP = 0;
   localparam int CT_S_RESP = 1;
   localparam int CT_SERR_EN = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;

   // Status bits, the same positions on both interfaces.
   localparam int ST_DET = 0;
   localparam int ST_DPD = 1;
   localparam int ST_SSE = 2;
   localparam logic [2:0] P_STAT_RST = 3'h0;
   localparam logic [1:0] S_STAT_RST = 2'h0;

   // Parity error output comes this many cycles after the data transfer.
   localparam int PERR_DLY = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Delayed write entry layout.
   localparam int ENT_W = 73;
   localparam int E_ADDR = 41;
   localparam int E_CMD = 37;
   localparam int E_DATA = 5;
   localparam int E_BE = 1;
   localparam int E_PAR = 0;
   localparam int DW_DEPTH = 2;

   typedef enum logic [1:0] {DW_EMPTY, DW_QUEUED, DW_STATUS} bpeh_dw_e;

endpackage : bpeh_pkg

/* File: bpeh_dwq_mem.sv */
// Two-entry delayed write store, one entry per direction, two read ports.
// Assumes the caller never writes an entry that a read port is using.
`timescale 1ns/1ps
`default_nettype none

module bpeh_dwq_mem
   import bpeh_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic en_in,
   input wire logic we_in,
   input wire logic waddr_in,
   input wire logic [ENT_W-1:0] wdata_in,
   input wire logic raddr_a_in,
   output logic [ENT_W-1:0] rdata_a_out,
   input wire logic raddr_b_in,
   output logic [ENT_W-1:0] rdata_b_out
);

   typedef struct packed {
      logic [DW_DEPTH-1:0][ENT_W-1:0] mem;
      logic [ENT_W-1:0] q_a;
      logic [ENT_W-1:0] q_b;
   } bpeh_mem_s;

   bpeh_mem_s m_r;
   bpeh_mem_s m_nxt;

   always_comb begin
      m_nxt = m_r;
      if (we_in) begin
         m_nxt.mem[waddr_in] = wdata_in;
      end
      // Reads see the old word when written in the same cycle.
      m_nxt.q_a = m_r.mem[raddr_a_in];
      m_nxt.q_b = m_r.mem[raddr_b_in];
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         m_r <= '0;
      end else if (en_in) begin
         m_r <= m_nxt;
      end
   end

   assign rdata_a_out = m_r.q_a;
   assign rdata_b_out = m_r.q_b;

endmodule : bpeh_dwq_mem

`default_nettype wire

/* File: bpeh_top.sv */
// Parity error detection, response and reporting for a two-sided bus bridge.
// Assumes bus engines on the same clock present sampled lines and event pulses.
`timescale 1ns/1ps
`default_nettype none

module bpeh_top
   import bpeh_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [31:0] p_ad_in,
   input wire logic [3:0] p_cbe_in,
   input wire logic p_par_in,
   input wire logic p_addr_phase_in,
   output logic p_no_claim_out,
   input wire logic [31:0] s_ad_in,
   input wire logic [3:0] s_cbe_in,
   input wire logic s_par_in,
   input wire logic s_addr_phase_in,
   output logic s_no_claim_out,
   output logic p_serr_out,
   output logic p_perr_out,
   output logic s_perr_out,
   input wire logic p_cfg_wr_in,
   output logic p_cfg_trdy_out,
   output logic p_cfg_we_out,
   input wire logic p_rd_dperr_in,
   input wire logic s_rd_dperr_in,
   input wire logic p_fwd_v_in,
   input wire logic p_fwd_par_in,
   input wire logic p_fwd_drop_in,
   input wire logic s_fwd_v_in,
   input wire logic s_fwd_par_in,
   input wire logic s_fwd_drop_in,
   output logic p_fwd_v_out,
   output logic p_fwd_par_out,
   output logic s_fwd_v_out,
   output logic s_fwd_par_out,
   input wire logic dw_req_in,
   input wire logic dw_up_in,
   input wire logic dw_multi_in,
   input wire logic [31:0] dw_addr_in,
   input wire logic [3:0] dw_cmd_in,
   input wire logic [31:0] dw_data_in,
   input wire logic [3:0] dw_be_in,
   input wire logic dw_par_in,
   output logic dw_trdy_out,
   output logic dw_stop_out,
   output logic dw_retry_out,
   output logic dw_done_out,
   output logic tgt_req_out,
   output logic tgt_up_out,
   output logic [31:0] tgt_addr_out,
   output logic [3:0] tgt_cmd_out,
   output logic [31:0] tgt_data_out,
   output logic [3:0] tgt_be_out,
   output logic tgt_par_out,
   input wire logic tgt_done_in,
   input wire logic tgt_perr_in
);

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      logic p_resp;
      logic s_resp;
      logic serr_en;
      logic [2:0] p_stat;
      logic [1:0] s_stat;
      logic [PERR_DLY-1:0] p_perr_pipe;
      logic [PERR_DLY-1:0] s_perr_pipe;
      logic serr;
      logic [31:0] rdata;
      logic p_fwd_v;
      logic p_fwd_par;
      logic s_fwd_v;
      logic s_fwd_par;
      bpeh_dw_e [DW_DEPTH-1:0] dw_st;
      logic [DW_DEPTH-1:0] dw_err;
      logic rq_v;
      logic rq_up;
      logic rq_multi;
      logic rq_perr;
      logic [ENT_W-1:0] rq_ent;
      logic tgt_act;
      logic tgt_sel;
   } bpeh_state_s;

   bpeh_state_s s_r;
   bpeh_state_s s_nxt;

   // Even parity over the address or data lines, the byte lanes and parity.
   function automatic logic par_err(
      input logic [31:0] ad,
      input logic [3:0] cbe,
      input logic par
   );
      par_err = ^{ad, cbe, par};
   endfunction : par_err

   logic p_ape;
   logic s_ape;
   logic p_cfg_pe;
   logic ir;
   logic tr;
   logic match;
   logic m_we;
   logic trdy;
   logic stop;
   logic retry;
   logic done;
   logic i_det;
   logic i_pev;
   logic p_det;
   logic p_dpd;
   logic s_det;
   logic s_dpd;
   logic p_pev;
   logic s_pev;
   logic sse;
   logic [2:0] p_clr;
   logic [1:0] s_clr;
   logic [ENT_W-1:0] head_ent;
   logic [ENT_W-1:0] tgt_ent;

   ////////////////////////////////////////////////////////////////////////////////
   // Address and configuration write parity.

   assign p_ape = p_addr_phase_in & par_err(p_ad_in, p_cbe_in, p_par_in);
   assign s_ape = s_addr_phase_in & par_err(s_ad_in, s_cbe_in, s_par_in);
   assign p_no_claim_out = p_ape & s_r.p_resp;
   assign s_no_claim_out = s_ape & s_r.s_resp;

   // The write goes ahead even with bad data, so software sees what arrived.
   assign p_cfg_pe = p_cfg_wr_in & par_err(p_ad_in, p_cbe_in, p_par_in);
   assign p_cfg_trdy_out = p_cfg_wr_in;
   assign p_cfg_we_out = p_cfg_wr_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Delayed write evaluation, one cycle after the request is taken.

   assign ir = s_r.rq_up ? s_r.s_resp : s_r.p_resp;
   assign tr = s_r.rq_up ? s_r.p_resp : s_r.s_resp;
   assign match = (s_r.rq_ent[ENT_W-1:E_BE] == head_ent[ENT_W-1:E_BE]);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      s_nxt = s_r;
      m_we = 1'b0;
      trdy = 1'b0;
      stop = 1'b0;
      retry = 1'b0;
      done = 1'b0;
      i_det = 1'b0;
      i_pev = 1'b0;
      p_dpd = 1'b0;
      s_dpd = 1'b0;
      p_clr = 3'h0;
      s_clr = 2'h0;

      p_det = p_ape | p_cfg_pe | p_rd_dperr_in;
      s_det = s_ape | s_rd_dperr_in;
      sse = s_r.serr_en & ((p_ape & s_r.p_resp) | (s_ape & s_r.s_resp));
      p_pev = (p_cfg_pe | p_rd_dperr_in) & s_r.p_resp;
      s_pev = s_rd_dperr_in & s_r.s_resp;
      p_dpd = p_rd_dperr_in & s_r.p_resp;
      s_dpd = s_rd_dperr_in & s_r.s_resp;

      // Returned read parity is the initiator's to report; no input watches it.
      // Request evaluation.
      if (s_r.rq_v) begin
         i_det = s_r.rq_perr;
         case (s_r.dw_st[s_r.rq_up])
            DW_EMPTY: begin
               if (s_r.rq_perr && ir) begin
                  trdy = 1'b1;
                  stop = s_r.rq_multi;
                  i_pev = 1'b1;
               end else begin
                  retry = 1'b1;
                  m_we = 1'b1;
                  s_nxt.dw_st[s_r.rq_up] = DW_QUEUED;
                  s_nxt.dw_err[s_r.rq_up] = 1'b0;
               end
            end
            DW_QUEUED: begin
               retry = 1'b1;
            end
            DW_STATUS: begin
               if (s_r.rq_perr) begin
                  trdy = 1'b1;
                  i_pev = ir;
               end else if (match) begin
                  trdy = 1'b1;
                  done = 1'b1;
                  s_nxt.dw_st[s_r.rq_up] = DW_EMPTY;
                  i_pev = s_r.dw_err[s_r.rq_up] & ir & tr;
               end else begin
                  retry = 1'b1;
               end
            end
            default: begin
               s_nxt.dw_st[s_r.rq_up] = DW_EMPTY;
            end
         endcase
      end

      if (s_r.rq_up) begin
         s_det = s_det | i_det;
         s_pev = s_pev | i_pev;
      end else begin
         p_det = p_det | i_det;
         p_pev = p_pev | i_pev;
      end

      // Delivery to the target, downstream entry first.
      if (s_r.tgt_act) begin
         if (tgt_done_in) begin
            s_nxt.tgt_act = 1'b0;
            s_nxt.dw_st[s_r.tgt_sel] = DW_STATUS;
            s_nxt.dw_err[s_r.tgt_sel] = tgt_perr_in;
            if (s_r.tgt_sel) begin
               p_dpd = p_dpd | (tgt_perr_in & s_r.p_resp);
            end else begin
               s_dpd = s_dpd | (tgt_perr_in & s_r.s_resp);
            end
         end
      end else if (s_r.dw_st[0] == DW_QUEUED) begin
         s_nxt.tgt_act = 1'b1;
         s_nxt.tgt_sel = 1'b0;
      end else if (s_r.dw_st[1] == DW_QUEUED) begin
         s_nxt.tgt_act = 1'b1;
         s_nxt.tgt_sel = 1'b1;
      end

      // Parity error outputs trail the transfer by a fixed pipe.
      s_nxt.p_perr_pipe = {s_r.p_perr_pipe[PERR_DLY-2:0], p_pev};
      s_nxt.s_perr_pipe = {s_r.s_perr_pipe[PERR_DLY-2:0], s_pev};
      s_nxt.serr = sse;

      // Register writes.
      if (reg_wr_in) begin
         case (reg_addr_in)
            REG_CTRL: begin
               s_nxt.p_resp = reg_wdata_in[CT_P_RESP];
               s_nxt.s_resp = reg_wdata_in[CT_S_RESP];
               s_nxt.serr_en = reg_wdata_in[CT_SERR_EN];
            end
            REG_P_STAT: begin
               p_clr = reg_wdata_in[2:0];
            end
            REG_S_STAT: begin
               s_clr = reg_wdata_in[1:0];
            end
            default: begin
               p_clr = 3'h0;
            end
         endcase
      end

      // A set in the same cycle as its clear wins, so no event is lost.
      s_nxt.p_stat = s_r.p_stat & ~p_clr;
      s_nxt.p_stat[ST_DET] = s_nxt.p_stat[ST_DET] | p_det;
      s_nxt.p_stat[ST_DPD] = s_nxt.p_stat[ST_DPD] | p_dpd;
      s_nxt.p_stat[ST_SSE] = s_nxt.p_stat[ST_SSE] | sse;
      s_nxt.s_stat = s_r.s_stat & ~s_clr;
      s_nxt.s_stat[ST_DET] = s_nxt.s_stat[ST_DET] | s_det;
      s_nxt.s_stat[ST_DPD] = s_nxt.s_stat[ST_DPD] | s_dpd;

      // Register reads answer in the next cycle only.
      s_nxt.rdata = 32'h0;
      if (reg_rd_in) begin
         case (reg_addr_in)
            REG_CTRL: begin
               s_nxt.rdata = {29'h0, s_r.serr_en, s_r.s_resp, s_r.p_resp};
            end
            REG_P_STAT: begin
               s_nxt.rdata = {29'h0, s_r.p_stat};
            end
            REG_S_STAT: begin
               s_nxt.rdata = {30'h0, s_r.s_stat};
            end
            REG_DW_STATE: begin
               s_nxt.rdata = {25'h0, s_r.tgt_act, s_r.dw_err, s_r.dw_st[1], s_r.dw_st[0]};
            end
            default: begin
               s_nxt.rdata = 32'h0;
            end
         endcase
      end

      // Forwarded parity crosses with its data; dropped prefetch never returns.
      s_nxt.p_fwd_v = s_fwd_v_in & ~s_fwd_drop_in;
      s_nxt.s_fwd_v = p_fwd_v_in & ~p_fwd_drop_in;
      if (s_fwd_v_in) begin
         s_nxt.p_fwd_par = s_fwd_par_in;
      end
      if (p_fwd_v_in) begin
         s_nxt.s_fwd_par = p_fwd_par_in;
      end

      // Request capture, parity kept for forwarding to the target.
      s_nxt.rq_v = dw_req_in;
      if (dw_req_in) begin
         s_nxt.rq_up = dw_up_in;
         s_nxt.rq_multi = dw_multi_in;
         s_nxt.rq_perr = par_err(dw_data_in, dw_be_in, dw_par_in);
         s_nxt.rq_ent = {dw_addr_in, dw_cmd_in, dw_data_in, dw_be_in, dw_par_in};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_r <= '0;
      end else if (ce_in) begin
         s_r <= s_nxt;
      end
   end

   // The head entry is read at the request edge, so the match has it a cycle later.
   bpeh_dwq_mem u_mem (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .en_in(ce_in),
      .we_in(m_we),
      .waddr_in(s_r.rq_up),
      .wdata_in(s_r.rq_ent),
      .raddr_a_in(dw_up_in),
      .rdata_a_out(head_ent),
      .raddr_b_in(s_nxt.tgt_sel),
      .rdata_b_out(tgt_ent)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign reg_rdata_out = s_r.rdata;
   assign p_serr_out = s_r.serr;
   assign p_perr_out = s_r.p_perr_pipe[PERR_DLY-1];
   assign s_perr_out = s_r.s_perr_pipe[PERR_DLY-1];
   assign p_fwd_v_out = s_r.p_fwd_v;
   assign p_fwd_par_out = s_r.p_fwd_par;
   assign s_fwd_v_out = s_r.s_fwd_v;
   assign s_fwd_par_out = s_r.s_fwd_par;
   assign dw_trdy_out = trdy;
   assign dw_stop_out = stop;
   assign dw_retry_out = retry;
   assign dw_done_out = done;
   assign tgt_req_out = s_r.tgt_act;
   assign tgt_up_out = s_r.tgt_sel;
   assign tgt_addr_out = tgt_ent[E_ADDR+31:E_ADDR];
   assign tgt_cmd_out = tgt_ent[E_CMD+3:E_CMD];
   assign tgt_data_out = tgt_ent[E_DATA+31:E_DATA];
   assign tgt_be_out = tgt_ent[E_BE+3:E_BE];
   assign tgt_par_out = tgt_ent[E_PAR];

endmodule : bpeh_top

`default_nettype wire

/* File: bpeh_top_properties.sv */
// Port-level checks of the bridge parity error handler.
// Assumes ce_in stays high; bound to every bpeh_top.
`timescale 1ns/1ps
`default_nettype none
module bpeh_top_properties
   import bpeh_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [31:0] p_ad_in,
   input wire logic [3:0] p_cbe_in,
   input wire logic p_par_in,
   input wire logic p_addr_phase_in,
   input wire logic p_no_claim_out,
   input wire logic [31:0] s_ad_in,
   input wire logic [3:0] s_cbe_in,
   input wire logic s_par_in,
   input wire logic s_addr_phase_in,
   input wire logic s_no_claim_out,
   input wire logic p_serr_out,
   input wire logic p_perr_out,
   input wire logic s_perr_out,
   input wire logic p_cfg_wr_in,
   input wire logic p_cfg_trdy_out,
   input wire logic p_cfg_we_out,
   input wire logic p_rd_dperr_in,
   input wire logic s_rd_dperr_in,
   input wire logic p_fwd_v_in,
   input wire logic p_fwd_drop_in,
   input wire logic s_fwd_par_in,
   input wire logic p_fwd_v_out,
   input wire logic p_fwd_par_out,
   input wire logic s_fwd_v_out,
   input wire logic dw_req_in,
   input wire logic dw_multi_in,
   input wire logic dw_trdy_out,
   input wire logic dw_retry_out,
   input wire logic dw_stop_out,
   input wire logic dw_done_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   // Even parity, so a set XOR marks a bad phase.
   wire p_bad = ^{p_ad_in, p_cbe_in, p_par_in};
   wire s_bad = ^{s_ad_in, s_cbe_in, s_par_in};
   ////////////////////////////////////////
   AST_P_NOCLAIM: assert property (p_no_claim_out |-> p_addr_phase_in && p_bad)
      else $error("primary claim refused without bad address parity");
   AST_S_NOCLAIM: assert property (s_no_claim_out |-> s_addr_phase_in && s_bad)
      else $error("secondary claim refused without bad address parity");
   AST_SERR: assert property (p_serr_out |->
      $past(p_addr_phase_in && p_bad || s_addr_phase_in && s_bad))
      else $error("system error without a bad address phase");
   AST_CFG: assert property (p_cfg_wr_in |-> p_cfg_trdy_out && p_cfg_we_out)
      else $error("config write not accepted");
   AST_S_PERR: assert property (s_perr_out |->
      $past(s_rd_dperr_in, 2) || $past(dw_trdy_out, 2))
      else $error("secondary parity error at wrong time");
   AST_P_PERR: assert property (p_perr_out |-> $past(p_rd_dperr_in, 2) ||
      $past(p_cfg_wr_in, 2) || $past(dw_trdy_out, 2))
      else $error("primary parity error at wrong time");
   AST_FWD_V: assert property (s_fwd_v_out == $past(p_fwd_v_in && !p_fwd_drop_in))
      else $error("forwarded valid wrong");
   AST_FWD_PAR: assert property (p_fwd_v_out |-> p_fwd_par_out == $past(s_fwd_par_in))
      else $error("forwarded parity altered");
   AST_DW_ANS: assert property (dw_req_in |=> dw_trdy_out != dw_retry_out)
      else $error("delayed write not answered by exactly one of ready or retry");
   AST_STOP: assert property (dw_stop_out |-> dw_trdy_out && $past(dw_multi_in))
      else $error("stop without ready on a multi-phase request");
   C_NOCLAIM: cover property (p_no_claim_out);
   C_DONE: cover property (dw_done_out);
   C_STOP: cover property (dw_stop_out);
endmodule : bpeh_top_properties
bind bpeh_top bpeh_top_properties u_props (.*);
`default_nettype wire

/* File: bpeh_tgt_model.sv */
// Target on the far bus that takes delayed write deliveries.
// Assumes the bench sets its latency and whether it reports bad parity.
`timescale 1ns/1ps
`default_nettype none
module bpeh_tgt_model (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic tgt_req_in,
   input wire logic [3:0] lat_in,
   input wire logic perr_en_in,
   output logic tgt_done_out,
   output logic tgt_perr_out
);
   logic [3:0] cnt_r;
   ////////////////////////////////////////
   // The count restarts after each done so a request that is still high at the
   // done edge is not answered twice.
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r <= 4'h0;
         tgt_done_out <= 1'b0;
         tgt_perr_out <= 1'b0;
      end else if (tgt_req_in && !tgt_done_out) begin
         cnt_r <= cnt_r + 4'h1;
         tgt_done_out <= (cnt_r == lat_in);
         tgt_perr_out <= (cnt_r == lat_in) && perr_en_in;
      end else begin
         cnt_r <= 4'h0;
         tgt_done_out <= 1'b0;
         tgt_perr_out <= 1'b0;
      end
   end
endmodule : bpeh_tgt_model
`default_nettype wire

/* File: bpeh_top_bench.sv */
// Self-checking bench of the bridge parity error handler.
// Assumes the far-bus target model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module bpeh_top_bench;
   import bpeh_pkg::*;
   logic ref_clk_in, rst_in, ce_in, reg_wr_in, reg_rd_in, p_par_in, s_par_in, perr_en;
   logic [7:0] reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out, p_ad_in, s_ad_in, dw_addr_in, dw_data_in;
   logic [31:0] tgt_addr_out, tgt_data_out;
   logic [3:0] p_cbe_in, s_cbe_in, dw_cmd_in, dw_be_in, tgt_cmd_out, tgt_be_out, lat;
   logic p_addr_phase_in, p_no_claim_out, s_addr_phase_in, s_no_claim_out, p_serr_out;
   logic p_perr_out, s_perr_out, p_cfg_wr_in, p_cfg_trdy_out, p_cfg_we_out, p_rd_dperr_in;
   logic s_rd_dperr_in, p_fwd_v_in, p_fwd_par_in, p_fwd_drop_in, s_fwd_v_in, s_fwd_par_in;
   logic s_fwd_drop_in, p_fwd_v_out, p_fwd_par_out, s_fwd_v_out, s_fwd_par_out, dw_req_in;
   logic dw_up_in, dw_multi_in, dw_par_in, dw_trdy_out, dw_stop_out, dw_retry_out;
   logic dw_done_out, tgt_req_out, tgt_up_out, tgt_par_out, tgt_done_in, tgt_perr_in;
   logic [4:0] ans;
   logic [1:0] r2;
   logic [11:0] row;
   int errors, check_count, i;
   // Rows: ctrl[11:9] sec_bus[8] bad[7] no_claim[6] serr[5] p_stat[4:2] s_stat[1:0].
   localparam logic [11:0] ROWS [8] = '{12'h084, 12'h2c4, 12'haf4, 12'h884,
      12'he00, 12'h5c1, 12'hdf1, 12'hb81};
   localparam logic [31:0] DW_D = 32'h0000_a5c3;
   bpeh_top u_dut (.*);
   bpeh_tgt_model u_tgt (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .tgt_req_in(tgt_req_out),
      .lat_in(lat), .perr_en_in(perr_en), .tgt_done_out(tgt_done_in),
      .tgt_perr_out(tgt_perr_in));
   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   ////////////////////////////////////////
   task automatic final_report();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      check(reg_rdata_out, exp);
   endtask : rdc
   task automatic clr();
      wr(REG_P_STAT, 32'h7);
      wr(REG_S_STAT, 32'h3);
   endtask : clr
   // Returns the parity error outputs two cycles after a one-cycle event.
   task automatic ev(input logic [2:0] w, output logic [1:0] r);
      @(posedge ref_clk_in);
      {p_cfg_wr_in, p_rd_dperr_in, s_rd_dperr_in} <= w;
      @(posedge ref_clk_in);
      {p_cfg_wr_in, p_rd_dperr_in, s_rd_dperr_in} <= 3'h0;
      @(posedge ref_clk_in);
      #1;
      r = {p_perr_out, s_perr_out};
   endtask : ev
   task automatic dw(input logic up, input logic multi, input logic [31:0] d,
      input logic bad, output logic [4:0] r);
      @(posedge ref_clk_in);
      dw_req_in <= 1'b1;
      dw_up_in <= up;
      dw_multi_in <= multi;
      dw_data_in <= d;
      dw_par_in <= ^{d, dw_be_in} ^ bad;
      @(posedge ref_clk_in);
      dw_req_in <= 1'b0;
      #1;
      r[4:1] = {dw_trdy_out, dw_retry_out, dw_stop_out, dw_done_out};
      repeat (2) @(posedge ref_clk_in);
      #1;
      r[0] = up ? s_perr_out : p_perr_out;
   endtask : dw
   task automatic wait_req(input logic v);
      int k;
      for (k = 0; k < 20; k++) begin
         @(posedge ref_clk_in);
         #1;
         if (tgt_req_out === v) return;
      end
      errors++;
      final_report();
   endtask : wait_req
   ////////////////////////////////////////
   initial begin
      {rst_in, ce_in, lat, perr_en} = {1'b1, 1'b1, 4'h2, 1'b1};
      {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
      {p_ad_in, p_cbe_in, s_ad_in, s_cbe_in} = {32'h1234_5678, 4'h6, 32'h0f0f_1357, 4'h7};
      {p_par_in, s_par_in, p_addr_phase_in, s_addr_phase_in, p_cfg_wr_in} = '0;
      {p_rd_dperr_in, s_rd_dperr_in, p_fwd_v_in, p_fwd_par_in, p_fwd_drop_in} = '0;
      {s_fwd_v_in, s_fwd_par_in, s_fwd_drop_in, dw_req_in, dw_up_in, dw_multi_in} = '0;
      {dw_addr_in, dw_cmd_in, dw_data_in, dw_be_in, dw_par_in} = {32'h8000_0040, 4'h7, 32'h0, 4'hf, 1'b0};
      errors = 0;
      check_count = 0;
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rdc(REG_CTRL, 32'h0);
      rdc(REG_P_STAT, 32'h0);
      rdc(REG_DW_STATE, 32'h0);
      wr(8'h10, 32'hffff_ffff);
      rdc(8'h10, 32'h0);
      for (i = 0; i < 8; i++) begin
         row = ROWS[i];
         wr(REG_CTRL, {29'h0, row[11:9]});
         @(posedge ref_clk_in);
         {s_addr_phase_in, p_addr_phase_in} <= {row[8], ~row[8]};
         p_par_in <= row[7] ^ (^{p_ad_in, p_cbe_in});
         s_par_in <= row[7] ^ (^{s_ad_in, s_cbe_in});
         #1;
         check(row[8] ? s_no_claim_out : p_no_claim_out, row[6]);
         @(posedge ref_clk_in);
         {s_addr_phase_in, p_addr_phase_in} <= 2'h0;
         #1;
         check(p_serr_out, row[5]);
         rdc(REG_P_STAT, row[4:2]);
         rdc(REG_S_STAT, row[1:0]);
         wr(REG_P_STAT, 32'h0);
         rdc(REG_P_STAT, row[4:2]);
         clr();
      end
      p_par_in <= ~^{p_ad_in, p_cbe_in};
      for (i = 0; i < 2; i++) begin
         wr(REG_CTRL, i);
         ev(3'h4, r2);
         check(r2, {i[0], 1'b0});
         rdc(REG_P_STAT, 32'h1);
         clr();
      end
      for (i = 0; i < 8; i++) begin
         wr(REG_CTRL, i[1:0]);
         ev(i[2] ? 3'h1 : 3'h2, r2);
         check(r2, i[2] ? {1'b0, i[1]} : {i[0], 1'b0});
         rdc(REG_S_STAT, i[2] ? {i[1], 1'b1} : 2'h0);
         rdc(REG_P_STAT, i[2] ? 2'h0 : {i[0], 1'b1});
         clr();
      end
      // Initiator error reports on returned read data have no port here.
      @(posedge ref_clk_in);
      {p_fwd_v_in, p_fwd_par_in, s_fwd_v_in, s_fwd_par_in} <= 4'b1110;
      @(posedge ref_clk_in);
      {p_fwd_drop_in, s_fwd_drop_in} <= 2'h3;
      #1;
      check({s_fwd_v_out, s_fwd_par_out, p_fwd_v_out, p_fwd_par_out}, 4'b1110);
      @(posedge ref_clk_in);
      {p_fwd_v_in, p_fwd_drop_in, s_fwd_v_in, s_fwd_drop_in} <= 4'h0;
      #1;
      check({s_fwd_v_out, p_fwd_v_out}, 2'h0);
      wr(REG_CTRL, 32'h3);
      dw(1'b0, 1'b0, DW_D, 1'b0, ans);
      check(ans, 5'b01000);
      wait_req(1'b1);
      check({tgt_up_out, tgt_par_out, tgt_cmd_out, tgt_be_out}, {2'b00, 8'h7f});
      check(tgt_data_out, DW_D);
      check(tgt_addr_out, dw_addr_in);
      wait_req(1'b0);
      rdc(REG_DW_STATE, 32'h12);
      rdc(REG_S_STAT, 32'h2);
      dw(1'b0, 1'b0, DW_D, 1'b1, ans);
      check(ans, 5'b10001);
      rdc(REG_DW_STATE, 32'h12);
      rdc(REG_P_STAT, 32'h1);
      dw(1'b0, 1'b0, DW_D + 32'h1, 1'b0, ans);
      check(ans, 5'b01000);
      dw(1'b0, 1'b0, DW_D, 1'b0, ans);
      check(ans, 5'b10011);
      rdc(REG_DW_STATE, 32'h10);
      clr();
      dw(1'b1, 1'b1, DW_D, 1'b1, ans);
      check(ans, 5'b10101);
      rdc(REG_DW_STATE, 32'h10);
      clr();
      wr(REG_CTRL, 32'h1);
      perr_en <= 1'b0;
      dw(1'b1, 1'b0, DW_D, 1'b1, ans);
      check(ans, 5'b01000);
      rdc(REG_S_STAT, 32'h1);
      wait_req(1'b1);
      check({tgt_up_out, tgt_par_out}, 2'b11);
      // A second reset in mid-run must return the control register to zero.
      @(posedge ref_clk_in);
      rst_in <= 1'b1;
      @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rdc(REG_CTRL, 32'h0);
      final_report();
   end
endmodule : bpeh_top_bench
`default_nettype wire
